// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
	localparam int T = 10;
	logic        sys_clk   = 1'b0;
	logic        sys_rst   = 1'b1;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [11:0] paddr     = 12'h000;
	logic [31:0] pwdata    = 32'h00000000;
	logic        pready, pslverr, slide_det, slide_active;
	logic [31:0] prdata, rd;
	logic [1:0]  slide_speed;
	logic [13:0] touch_in, auto_recal_req, touch_valid, recal_active, analog_update, base_capture;
	logic        tap_event, hold_event, hold_repeat_event, slide_event, err;
	logic [13:0] cmd_touch = 14'h0000;
	logic [13:0] cmd_auto  = 14'h0000;
	logic        cmd_slide = 1'b0;
	logic [1:0]  cmd_speed = 2'h0;
	logic        mon_clr   = 1'b0;
	logic        grp_q     = 1'b0;
	logic [13:0] au_seen   = 14'h0000;
	logic [13:0] cap_seen  = 14'h0000;
	int          n_fail = 0, n_tests = 0, cyc = 0, run = 0, last_run = 0;
	int          n_tap = 0, n_hold = 0, n_rep = 0, n_slide = 0, t_hold = 0, t_rep = 0, t_grp = 0;
	int          a_tap, a_hold, a_rep, a_slide;
	logic [7:0]  ridx [8] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h46, 8'h30, 8'h31, 8'h32};
	logic [7:0]  rexp [8] = '{8'h47, 8'hD4, 8'hFF, 8'h00, 8'h00, 8'h01, 8'hFF, 8'h00};

	always #50 sys_clk = ~sys_clk;

	touch_group_ctrl #(.TICK_CYCLES(T)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .touch_in(touch_in), .auto_recal_req(auto_recal_req),
		.slide_det(slide_det), .slide_active(slide_active), .slide_speed(slide_speed),
		.touch_valid(touch_valid), .recal_active(recal_active), .analog_update(analog_update),
		.base_capture(base_capture), .tap_event(tap_event), .hold_event(hold_event),
		.hold_repeat_event(hold_repeat_event), .slide_event(slide_event));

	touch_pads pads (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_touch(cmd_touch), .cmd_auto(cmd_auto),
		.cmd_slide(cmd_slide), .cmd_speed(cmd_speed), .touch_in(touch_in), .auto_recal_req(auto_recal_req),
		.slide_det(slide_det), .slide_active(slide_active), .slide_speed(slide_speed));

	// ----------------------------------------------------------------
	// Output monitor
	// ----------------------------------------------------------------
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		au_seen <= mon_clr ? 14'h0000 : (au_seen | analog_update);
		cap_seen <= mon_clr ? 14'h0000 : (cap_seen | base_capture);
		run <= (|recal_active === 1'b1) ? run + 1 : 0;
		if (|recal_active !== 1'b1 && run != 0)
			last_run <= run;
		if (tap_event === 1'b1)
			n_tap <= n_tap + 1;
		if (slide_event === 1'b1)
			n_slide <= n_slide + 1;
		if (hold_event === 1'b1)
		begin
			n_hold <= n_hold + 1;
			t_hold <= cyc;
		end
		if (hold_repeat_event === 1'b1)
		begin
			n_rep <= n_rep + 1;
			if (t_rep <= t_hold)
				t_rep <= cyc;
		end
		if (|touch_in[13:7] === 1'b1 && !grp_q)
			t_grp <= cyc;
		grp_q <= (|touch_in[13:7] === 1'b1);
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// One APB transfer; waits for pready, never assumes a latency
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		int k;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h000000, wd};
		@(posedge sys_clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge sys_clk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20)
			chk("pready", 32'h1, 32'h0);
	endtask

	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk($sformatf("reg_%h", idx), {24'h000000, exp}, rd);
	endtask

	// Host retries by polling until the bits read back zero
	task automatic poll0(input logic [7:0] idx, input logic [31:0] mask);
		int k;
		k = 0;
		do
		begin
			apb(1'b0, idx, 8'h00);
			k++;
		end
		while ((rd & mask) !== 32'h0 && k < 300);
		chk($sformatf("clear_%h", idx), 32'h0, rd & mask);
	endtask

	task automatic touch(input logic [13:0] v);
		@(posedge sys_clk);
		cmd_touch <= v;
	endtask

	task automatic pulse(input logic [13:0] v, input logic s);
		@(posedge sys_clk);
		cmd_auto <= v;
		cmd_slide <= s;
		mon_clr <= 1'b1;
		@(posedge sys_clk);
		cmd_auto <= 14'h0000;
		cmd_slide <= 1'b0;
		mon_clr <= 1'b0;
	endtask

	task automatic snap();
		a_tap = n_tap;
		a_hold = n_hold;
		a_rep = n_rep;
		a_slide = n_slide;
	endtask

	task automatic wrap_up();
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Watchdog, far beyond the expected run of a few thousand cycles
	// ----------------------------------------------------------------
	initial
	begin
		#(100 * 60000);
		n_fail++;
		wrap_up();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial
	begin
		wt(5);
		sys_rst <= 1'b0;
		for (int i = 0; i < 8; i++)
			rdc(ridx[i], rexp[i]);
		apb(1'b0, 8'h7F, 8'h00);
		chk("unmapped", 32'h1, {31'h0, err});
		apb(1'b1, 8'h23, 8'h5A);
		rdc(8'h23, 8'h5A);
		apb(1'b1, 8'h24, 8'hA5);
		rdc(8'h24, 8'hA5);
		apb(1'b1, 8'h46, 8'h80);
		rdc(8'h46, 8'h00);
		touch(14'h0004);
		wt(3);
		chk("touch_valid", {18'h0, 14'h0004}, {18'h0, touch_valid});
		touch(14'h0000);
		// Manual recal of input one: start, length, self clear
		pulse(14'h0000, 1'b0);
		apb(1'b1, 8'h26, 8'h01);
		poll0(8'h26, 32'h01);
		wt(3);
		chk("cap_one", {18'h0, 14'h0001}, {18'h0, cap_seen});
		chk("au_one", {18'h0, 14'h0001}, {18'h0, au_seen});
		chk("recal_len", 32'h1, {31'h0, last_run >= 16 * T && last_run <= 17 * T + 2});
		// Touch mid-recal spoils the attempt, trigger stays set
		pulse(14'h0000, 1'b0);
		apb(1'b1, 8'h26, 8'h02);
		wt(30);
		touch(14'h0002);
		wt(5);
		chk("abort_active", 32'h0, {31'h0, recal_active[1]});
		rdc(8'h26, 8'h02);
		touch(14'h0000);
		poll0(8'h26, 32'h02);
		chk("cap_retry", 32'h1, {31'h0, cap_seen[1]});
		// Group trigger covers all grouped inputs
		apb(1'b1, 8'h26, 8'h80);
		wt(20);
		chk("grp_active", 32'h7F, {25'h0, recal_active[13:7]});
		touch(14'h0200);
		wt(5);
		rdc(8'h26, 8'h80);
		touch(14'h0000);
		poll0(8'h26, 32'h80);
		apb(1'b1, 8'h46, 8'h40);
		wt(5);
		chk("s14_active", {18'h0, 14'h2000}, {18'h0, recal_active});
		poll0(8'h46, 32'h7F);
		// Automatic requests gated by enable and sampling bits
		apb(1'b1, 8'h25, 8'hFD);
		pulse(14'h0003, 1'b0);
		wt(5);
		chk("auto_en", 32'h1, {30'h0, recal_active[1:0]});
		poll0(8'h32, 32'h3FFF);
		apb(1'b1, 8'h25, 8'hFF);
		apb(1'b1, 8'h31, 8'hFE);
		pulse(14'h0003, 1'b0);
		wt(5);
		chk("auto_samp", 32'h2, {30'h0, recal_active[1:0]});
		poll0(8'h32, 32'h3FFF);
		apb(1'b1, 8'h31, 8'hFF);
		apb(1'b1, 8'h25, 8'h7F);
		pulse(14'h0100, 1'b0);
		wt(5);
		chk("grp_auto_off", 32'h0, {25'h0, recal_active[13:7]});
		apb(1'b1, 8'h25, 8'hFF);
		pulse(14'h0100, 1'b0);
		wt(5);
		chk("grp_auto_on", 32'h1, {31'h0, |recal_active[13:7]});
		poll0(8'h32, 32'h3FFF);
		// Tap, press-and-hold with repeat, slide during press
		apb(1'b1, 8'h23, 8'h21);
		snap();
		touch(14'h0100);
		wt(4);
		touch(14'h0000);
		wt(5);
		chk("tap", 32'h1, n_tap - a_tap);
		chk("tap_no_hold", 32'h0, n_hold - a_hold);
		snap();
		touch(14'h0080);
		wt(4 * T);
		pulse(14'h0000, 1'b1);
		wt(4 * T);
		touch(14'h0000);
		wt(5);
		chk("hold", 32'h1, n_hold - a_hold);
		chk("hold_no_tap", 32'h0, n_tap - a_tap);
		chk("hold_delay", 32'h1, {31'h0, t_hold - t_grp >= 2 * T && t_hold - t_grp <= 3 * T + 3});
		chk("rep_gap", 3 * T, t_rep - t_hold);
		chk("rep_cnt", 32'h1, {31'h0, n_rep - a_rep >= 1 && n_rep - a_rep <= 2});
		chk("slide", 32'h1, n_slide - a_slide);
		snap();
		pulse(14'h0000, 1'b1);
		wt(3);
		chk("slide_alone", 32'h1, n_slide - a_slide);
		// Held slide, base code 5 halved by speed 1: one event per 3 ticks
		snap();
		cmd_speed <= 2'h1;
		cmd_slide <= 1'b1;
		wt(12 * T);
		cmd_slide <= 1'b0;
		wt(3);
		chk("slide_rpt", 32'h1, {31'h0, n_slide - a_slide >= 4 && n_slide - a_slide <= 5});
		// Overlong press: max-press recal off, then on
		apb(1'b1, 8'h24, 8'h04);
		apb(1'b1, 8'h30, 8'h00);
		snap();
		pulse(14'h0000, 1'b0);
		touch(14'h0080);
		wt(20 * T);
		chk("no_rep", 32'h0, n_rep - a_rep);
		chk("max_off", 32'h0, {25'h0, au_seen[13:7]});
		touch(14'h0000);
		apb(1'b1, 8'h30, 8'h02);
		pulse(14'h0000, 1'b0);
		touch(14'h0080);
		wt(20 * T);
		chk("max_on", 32'h1, {31'h0, |au_seen[13:7]});
		touch(14'h0000);
		poll0(8'h32, 32'h3FFF);
		wrap_up();
	end
endmodule

`default_nettype wire

// ---- touch_group_ctrl.sv ----
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Upper nibble of hold timing sets press-and-hold repeat interval, 35 ms steps.
// - Lower nibble sets minimum press time (code+1) x 35 ms, reset 0111b.
// - Grouped touch longer than minimum press time gives a press-and-hold event.
// - Grouped touch not longer than minimum press time gives a tap event.
// - Slides are independent of minimum press time and reported separately.
// - Upper nibble of second timing register is longest grouped press, reset 1101b.
// - Lower nibble is base slide repeat interval, adjusted by slide speed.
// - Auto recalibration only when enabled, ignored for sensors not sampled.
// - Bit 7 enables auto recalibration of all grouped channels together.
// - Bits 0-6 enable auto recalibration of inputs one to seven; reset all ones.
// - Manual bit starts recalibration and clears itself when it finishes.
// - Recalibration updates analog settings first, then captures base count.
// - During recalibration presses are not reported and base count is invalid.
// - Touch during recalibration invalidates that attempt.
// - Group manual bit recalibrates all grouped sensors, clears after all succeed.
// - First activate register bits 0-6 trigger inputs one to seven.
// - Second activate register bits 0-6 trigger inputs eight to fourteen.
// - With max-press recal enabled, overlong grouped press restarts recalibration.
// - With repeat enabled, hold interrupt repeats each interval while pressed.
module touch_group_ctrl #(
	parameter int unsigned TICK_CYCLES = touch_pkg::TICK_CYCLES
) (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic [13:0] touch_in,
	input  wire logic [13:0] auto_recal_req,
	input  wire logic        slide_det,
	input  wire logic        slide_active,
	input  wire logic [1:0]  slide_speed,
	output logic [13:0]      touch_valid,
	output logic [13:0]      recal_active,
	output logic [13:0]      analog_update,
	output logic [13:0]      base_capture,
	output logic             tap_event,
	output logic             hold_event,
	output logic             hold_repeat_event,
	output logic             slide_event
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [18:0]      tick_cnt;
		logic [7:0]       hold_timing;
		logic [7:0]       dur_slide;
		logic [7:0]       auto_en;
		logic [7:0]       man_trig;
		logic [6:0]       grp_trig;
		logic [1:0]       ctrl;
		logic [7:0]       samp_en;
		logic [6:0]       grp_done;
		logic [13:0][4:0] rc_cnt;
		logic [13:0]      rc_active;
		logic [13:0]      analog_upd;
		logic [13:0]      base_cap;
		logic [13:0]      valid;
		logic [8:0]       press_ticks;
		logic             pressed;
		logic             held;
		logic             max_fired;
		logic [4:0]       rpt_ticks;
		logic [4:0]       slide_ticks;
		logic             tap;
		logic             hold;
		logic             hold_rpt;
		logic             slide;
		logic             ready;
		logic [31:0]      rdata;
		logic             slverr;
	} state_t;

	state_t r;
	state_t next_r;

	function automatic logic [11:0] addr_of(input logic [7:0] idx);
		addr_of = {2'b00, idx, 2'b00};
	endfunction

	logic        tick;
	logic        setup;
	logic        wr;
	logic        hit;
	logic [31:0] rd_val;
	logic        grp_touch;
	logic [4:0]  mpress;
	logic [4:0]  hold_iv;
	logic [4:0]  slide_iv;
	logic [13:0] cen;
	logic [13:0] start_req;
	logic        grp_all_done;

	// ----------------------------------------------------------------
	// Register read decode
	// ----------------------------------------------------------------
	always_comb
	begin
		hit = 1'b1;
		rd_val = 32'h0000_0000;
		unique case (paddr)
			addr_of(touch_pkg::IDX_GROUP_HOLD_TIMING):  rd_val[7:0] = r.hold_timing;
			addr_of(touch_pkg::IDX_GROUP_DUR_SLIDE):    rd_val[7:0] = r.dur_slide;
			addr_of(touch_pkg::IDX_AUTO_RECAL_ENABLE):  rd_val[7:0] = r.auto_en;
			addr_of(touch_pkg::IDX_MANUAL_RECAL_TRIG):  rd_val[7:0] = r.man_trig;
			addr_of(touch_pkg::IDX_GROUPED_RECAL_TRIG): rd_val[6:0] = r.grp_trig;
			addr_of(touch_pkg::IDX_GROUP_CTRL):         rd_val[1:0] = r.ctrl;
			addr_of(touch_pkg::IDX_SAMPLE_ENABLE):      rd_val[7:0] = r.samp_en;
			addr_of(touch_pkg::IDX_RECAL_STATUS):       rd_val[13:0] = r.rc_active;
			default:                                    hit = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_r = r;
		// One shared 35 ms tick drives every interval
		tick = (r.tick_cnt == 19'(TICK_CYCLES - 1));
		next_r.tick_cnt = tick ? 19'h0_0000 : r.tick_cnt + 19'h0_0001;

		// Ready one cycle after setup, so the access phase lasts one cycle
		setup = psel && !penable && !r.ready;
		wr = psel && penable && r.ready && pwrite;
		next_r.ready = setup;
		next_r.rdata = setup && !pwrite && hit ? rd_val : 32'h0000_0000;
		next_r.slverr = setup && !hit;

		mpress = touch_pkg::rate_ticks(r.hold_timing[3:0]);
		hold_iv = touch_pkg::rate_ticks(r.hold_timing[7:4]);
		// Faster slides shorten the repeat interval, never below one tick
		slide_iv = touch_pkg::rate_ticks(r.dur_slide[3:0]) >> slide_speed;
		if (slide_iv == 5'h00)
			slide_iv = 5'h01;

		for (int i = 0; i < touch_pkg::NUM_SENSORS; i++)
		begin
			// Grouped channels share bit 7; unsampled sensors never auto recal
			if (i < touch_pkg::NUM_SINGLE)
				cen[i] = r.auto_en[i] && r.samp_en[i];
			else
				cen[i] = r.auto_en[touch_pkg::BIT_GROUP] && r.samp_en[touch_pkg::BIT_GROUP];
		end

		grp_touch = |r.valid[13:7];
		start_req = cen & auto_recal_req;
		start_req[6:0] = start_req[6:0] | r.man_trig[6:0];
		start_req[13:7] = start_req[13:7] | r.grp_trig
			| ({7{r.man_trig[touch_pkg::BIT_GROUP]}} & ~r.grp_done);

		// Overlong grouped press forces the untouched grouped sensors through recalibration
		if (r.ctrl[touch_pkg::BIT_GROUP_MAX_RECAL_EN] && r.pressed && !r.max_fired
			&& r.press_ticks > touch_pkg::max_dur_ticks(r.dur_slide[7:4]))
		begin
			start_req[13:7] = 7'h7F;
			next_r.max_fired = 1'b1;
		end

		// Recalibration per sensor: analog step at start, base capture at end
		next_r.analog_upd = 14'h0000;
		next_r.base_cap = 14'h0000;
		for (int i = 0; i < touch_pkg::NUM_SENSORS; i++)
		begin
			if (r.rc_active[i] && touch_in[i])
			begin
				// Attempt spoiled; trigger bit stays set and retries on release
				next_r.rc_active[i] = 1'b0;
				next_r.rc_cnt[i] = 5'h00;
			end
			else if (r.rc_active[i])
			begin
				if (tick && r.rc_cnt[i] == 5'h01)
				begin
					next_r.rc_active[i] = 1'b0;
					next_r.rc_cnt[i] = 5'h00;
					next_r.base_cap[i] = 1'b1;
				end
				else if (tick)
					next_r.rc_cnt[i] = r.rc_cnt[i] - 5'h01;
			end
			else if (start_req[i] && !touch_in[i])
			begin
				next_r.rc_active[i] = 1'b1;
				next_r.rc_cnt[i] = touch_pkg::RECAL_TICKS;
				next_r.analog_upd[i] = 1'b1;
			end
			// Presses are hidden while the base count is being rebuilt
			next_r.valid[i] = touch_in[i] && !next_r.rc_active[i];
		end

		// Self clearing triggers; a host write in the same cycle wins
		next_r.man_trig[6:0] = r.man_trig[6:0] & ~next_r.base_cap[6:0];
		next_r.grp_trig = r.grp_trig & ~next_r.base_cap[13:7];
		next_r.grp_done = r.grp_done;
		if (r.man_trig[touch_pkg::BIT_GROUP])
			next_r.grp_done = r.grp_done | next_r.base_cap[13:7];
		grp_all_done = &next_r.grp_done;
		if (grp_all_done)
		begin
			next_r.man_trig[touch_pkg::BIT_GROUP] = 1'b0;
			next_r.grp_done = 7'h00;
		end

		if (wr)
		begin
			unique case (paddr)
				addr_of(touch_pkg::IDX_GROUP_HOLD_TIMING):  next_r.hold_timing = pwdata[7:0];
				addr_of(touch_pkg::IDX_GROUP_DUR_SLIDE):    next_r.dur_slide = pwdata[7:0];
				addr_of(touch_pkg::IDX_AUTO_RECAL_ENABLE):  next_r.auto_en = pwdata[7:0];
				addr_of(touch_pkg::IDX_MANUAL_RECAL_TRIG):  next_r.man_trig = next_r.man_trig | pwdata[7:0];
				addr_of(touch_pkg::IDX_GROUPED_RECAL_TRIG): next_r.grp_trig = next_r.grp_trig | pwdata[6:0];
				addr_of(touch_pkg::IDX_GROUP_CTRL):         next_r.ctrl = pwdata[1:0];
				addr_of(touch_pkg::IDX_SAMPLE_ENABLE):      next_r.samp_en = pwdata[7:0];
				default:                                    next_r.ctrl = next_r.ctrl;
			endcase
		end

		// Grouped press timing: tap on short release, hold when threshold passed
		next_r.tap = 1'b0;
		next_r.hold = 1'b0;
		next_r.hold_rpt = 1'b0;
		if (grp_touch)
		begin
			next_r.pressed = 1'b1;
			if (tick && r.press_ticks != 9'h1FF)
				next_r.press_ticks = r.press_ticks + 9'h001;
			if (tick && !r.held && r.press_ticks == {4'h0, mpress})
			begin
				next_r.held = 1'b1;
				next_r.hold = 1'b1;
				next_r.rpt_ticks = 5'h00;
			end
			else if (tick && r.held)
			begin
				if (r.rpt_ticks + 5'h01 >= hold_iv)
				begin
					next_r.rpt_ticks = 5'h00;
					next_r.hold_rpt = r.ctrl[touch_pkg::BIT_GROUP_REPEAT_EN];
				end
				else
					next_r.rpt_ticks = r.rpt_ticks + 5'h01;
			end
		end
		else
		begin
			next_r.tap = r.pressed && !r.held;
			next_r.pressed = 1'b0;
			next_r.held = 1'b0;
			next_r.max_fired = 1'b0;
			next_r.press_ticks = 9'h000;
			next_r.rpt_ticks = 5'h00;
		end

		// Slides run on their own counter, untouched by press timing
		next_r.slide = 1'b0;
		if (slide_det)
		begin
			next_r.slide = 1'b1;
			next_r.slide_ticks = 5'h00;
		end
		else if (slide_active && tick)
		begin
			if (r.slide_ticks + 5'h01 >= slide_iv)
			begin
				next_r.slide = 1'b1;
				next_r.slide_ticks = 5'h00;
			end
			else
				next_r.slide_ticks = r.slide_ticks + 5'h01;
		end
		else if (!slide_active)
			next_r.slide_ticks = 5'h00;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			r <= '0;
			r.hold_timing <= touch_pkg::RST_GROUP_HOLD_TIMING;
			r.dur_slide <= touch_pkg::RST_GROUP_DUR_SLIDE;
			r.auto_en <= touch_pkg::RST_AUTO_RECAL_ENABLE;
			r.man_trig <= touch_pkg::RST_MANUAL_RECAL_TRIG;
			r.grp_trig <= touch_pkg::RST_GROUPED_RECAL_TRIG;
			r.ctrl <= touch_pkg::RST_GROUP_CTRL;
			r.samp_en <= touch_pkg::RST_SAMPLE_ENABLE;
		end
		else
			r <= next_r;
	end

	assign pready = r.ready;
	assign prdata = r.rdata;
	assign pslverr = r.slverr;
	assign touch_valid = r.valid;
	assign recal_active = r.rc_active;
	assign analog_update = r.analog_upd;
	assign base_capture = r.base_cap;
	assign tap_event = r.tap;
	assign hold_event = r.hold;
	assign hold_repeat_event = r.hold_rpt;
	assign slide_event = r.slide;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	sequence recal_begin(int k);
		analog_update[k] && recal_active[k];
	endsequence

	sequence recal_end(int k);
		base_capture[k] && !recal_active[k];
	endsequence

	chk_hold_after_min: assert property (
		$rose(hold_event) |-> $past(r.press_ticks) == {4'h0, touch_pkg::rate_ticks($past(r.hold_timing[3:0]))})
		else $error("hold not at minimum press time");

	chk_tap_short: assert property (
		tap_event |-> !$past(r.held) && $past(r.press_ticks) <= 9'(touch_pkg::rate_ticks($past(r.hold_timing[3:0]))))
		else $error("tap after a long press");

	chk_recal_phase: assert property (
		recal_begin(0) ##1 (recal_active[0] && !touch_in[0])[*2] |-> !base_capture[0])
		else $error("base captured too early");

	chk_recal_finish: assert property (
		base_capture[0] |-> recal_end(0) and $past(recal_active[0]) && !touch_valid[0])
		else $error("capture without active recal");

	chk_touch_abort: assert property (
		recal_active[1] && touch_in[1] |=> !recal_active[1] && !base_capture[1])
		else $error("touch did not abort recal");

	chk_trig_clear: assert property (
		$fell(r.man_trig[1]) |-> base_capture[1])
		else $error("trigger cleared without success");

	chk_group_clear: assert property (
		$fell(r.man_trig[7]) |-> ($past(r.grp_done) | base_capture[13:7]) == 7'h7F || (&$past(r.grp_done)))
		else $error("group trigger cleared early");

	chk_auto_gate: assert property (
		$rose(recal_active[1]) && !$past(r.man_trig[1]) |-> $past(r.auto_en[1] && r.samp_en[1]))
		else $error("auto recal while disabled");

	chk_repeat_gate: assert property (
		hold_repeat_event |-> $past(r.held) && $past(r.ctrl[0]))
		else $error("repeat without hold or enable");

	chk_apb_ready: assert property (
		psel && !penable && !pready |=> pready ##1 !pready)
		else $error("apb answer timing wrong");

endmodule

`default_nettype wire

// ---- touch_pads.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Sensing pad and front end stand-in
// ----------------------------------------------------------------
module touch_pads (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic [13:0] cmd_touch,
	input  wire logic [13:0] cmd_auto,
	input  wire logic        cmd_slide,
	input  wire logic [1:0]  cmd_speed,
	output logic [13:0]      touch_in,
	output logic [13:0]      auto_recal_req,
	output logic             slide_det,
	output logic             slide_active,
	output logic [1:0]       slide_speed
);
	logic slide_q;

	// Registered so every pad change lands just after an edge
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			touch_in       <= 14'h0000;
			auto_recal_req <= 14'h0000;
			slide_det      <= 1'b0;
			slide_active   <= 1'b0;
			slide_q        <= 1'b0;
			slide_speed    <= 2'h0;
		end
		else
		begin
			touch_in       <= cmd_touch;
			auto_recal_req <= cmd_auto;
			slide_det      <= cmd_slide & ~slide_q;
			slide_active   <= cmd_slide;
			slide_q        <= cmd_slide;
			slide_speed    <= cmd_speed;
		end
	end
endmodule

`default_nettype wire

// ---- touch_pkg.sv ----
package touch_pkg;

	// ----------------------------------------------------------------
	// Register indices, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_GROUP_HOLD_TIMING   = 8'h23;
	localparam logic [7:0] IDX_GROUP_DUR_SLIDE     = 8'h24;
	localparam logic [7:0] IDX_AUTO_RECAL_ENABLE   = 8'h25;
	localparam logic [7:0] IDX_MANUAL_RECAL_TRIG   = 8'h26;
	localparam logic [7:0] IDX_GROUPED_RECAL_TRIG  = 8'h46;
	localparam logic [7:0] IDX_GROUP_CTRL          = 8'h30;
	localparam logic [7:0] IDX_SAMPLE_ENABLE       = 8'h31;
	localparam logic [7:0] IDX_RECAL_STATUS        = 8'h32;

	// ----------------------------------------------------------------
	// Reset values and field positions
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_GROUP_HOLD_TIMING   = 8'h47;
	localparam logic [7:0] RST_GROUP_DUR_SLIDE     = 8'hD4;
	localparam logic [7:0] RST_AUTO_RECAL_ENABLE   = 8'hFF;
	localparam logic [7:0] RST_MANUAL_RECAL_TRIG   = 8'h00;
	localparam logic [6:0] RST_GROUPED_RECAL_TRIG  = 7'h00;
	localparam logic [1:0] RST_GROUP_CTRL          = 2'h1;
	localparam logic [7:0] RST_SAMPLE_ENABLE       = 8'hFF;
	localparam int         BIT_GROUP_REPEAT_EN     = 0;
	localparam int         BIT_GROUP_MAX_RECAL_EN  = 1;
	localparam int         BIT_GROUP               = 7;
	localparam int         NUM_SENSORS             = 14;
	localparam int         NUM_SINGLE              = 7;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int         CLK_HZ                  = 10000000;
	localparam int         TIMEBASE_MS             = 35;
	localparam int         RECAL_MS                = 600;
	localparam int         TICK_CYCLES             = TIMEBASE_MS * (CLK_HZ / 1000);
	localparam logic [4:0] RECAL_TICKS             = 5'(RECAL_MS / TIMEBASE_MS);

	// Repeat and minimum press codes: (code + 1) ticks of 35 ms
	function automatic logic [4:0] rate_ticks(input logic [3:0] code);
		rate_ticks = {1'b0, code} + 5'h01;
	endfunction

	// Longest grouped press in ms, rounded down to whole ticks
	function automatic logic [8:0] max_dur_ticks(input logic [3:0] code);
		int ms;
		ms = 560;
		unique case (code)
			4'h0: ms = 560;
			4'h1: ms = 840;
			4'h2: ms = 1120;
			4'h3: ms = 1400;
			4'h4: ms = 1680;
			4'h5: ms = 2240;
			4'h6: ms = 2800;
			4'h7: ms = 3360;
			4'h8: ms = 3920;
			4'h9: ms = 4480;
			4'hA: ms = 5600;
			4'hB: ms = 6720;
			4'hC: ms = 7840;
			4'hD: ms = 8906;
			4'hE: ms = 10080;
			4'hF: ms = 11200;
		endcase
		max_dur_ticks = 9'(ms / TIMEBASE_MS);
	endfunction

endpackage
